/* File: logic/iopdc_defines.vh */
`ifndef IOPDC_DEFINES_VH
`define IOPDC_DEFINES_VH
// ************************************************************
// port addresses
// ************************************************************
`define IOPDC_A_PIC0 16'h0020
`define IOPDC_A_SETUP_IDX 16'h0022
`define IOPDC_A_SETUP_DAT 16'h0023
`define IOPDC_A_PIT0 16'h0040
`define IOPDC_A_PIT3 16'h0043
`define IOPDC_A_CTLB 16'h0061
`define IOPDC_A_CLK_IDX 16'h0070
`define IOPDC_A_CLK_DAT 16'h0071
`define IOPDC_A_SCR0 16'h0080
`define IOPDC_A_SCR1 16'h0084
`define IOPDC_A_SCR2 16'h0086
`define IOPDC_A_SCR3 16'h0088
`define IOPDC_A_SCR4 16'h008C
`define IOPDC_A_SCR5 16'h008F
`define IOPDC_A_CTLA 16'h0092
`define IOPDC_A_DMA0 16'h00C0
`define IOPDC_A_DMA1 16'h00DE
`define IOPDC_A_A20 16'h00EE
`define IOPDC_A_CPURST 16'h00EF
`define IOPDC_A_MONO_IDX 16'h03B4
`define IOPDC_A_MONO_DAT 16'h03B5
`define IOPDC_A_COL_IDX 16'h03D4
`define IOPDC_A_COL_DAT 16'h03D5
`define IOPDC_A_CARD_IDX 16'h03E0
`define IOPDC_A_CARD_DAT 16'h03E1
// ************************************************************
// setup space indexes and fields
// ************************************************************
`define IOPDC_X_FEAT 8'hF0
`define IOPDC_X_ROMSEL 8'hF1
`define IOPDC_X_STRAP 8'hF2
`define IOPDC_F_GFX 0
`define IOPDC_F_LBUS 1
`define IOPDC_F_DRAM32 2
`define IOPDC_F_IRDA 3
`define IOPDC_F_ROM_EN 4
`define IOPDC_RST_BYTE 8'h00
`define IOPDC_ROM32 2'b10
// ************************************************************
// select encodings
// ************************************************************
`define IOPDC_S_NONE 4'h0
`define IOPDC_S_PIC 4'h1
`define IOPDC_S_PIT 4'h2
`define IOPDC_S_CTLB 4'h3
`define IOPDC_S_CLOCK 4'h4
`define IOPDC_S_SCR 4'h5
`define IOPDC_S_DMA 4'h6
`define IOPDC_S_GFX 4'h7
`define IOPDC_S_CARD 4'h8
`define IOPDC_S_LOCAL 4'h9
`define IOPDC_S_SETUP 4'hA
`endif

/* File: logic/iopdc_top.v */
`include "iopdc_defines.vh"

//
// Contract
// [R01] capture strap pins while reset asserted
// [R02] after reset pins serve dram interface
// [R03] straps weakly pulled down, default low
// [R04] setup space index 22h, data 23h
// [R05] interrupt controller claimed at 20h-21h
// [R06] interval timer claimed at 40h-43h
// [R07] control port b at 61h
// [R08] dma controller even addresses C0h-DEh
// [R09] scratch ports 80h, 84h-86h, 88h, 8Ch-8Fh
// [R10] control port a byte register 92h
// [R11] address-line-20 gate port EEh
// [R12] cpu reset port EFh
// [R13] mono graphics index/data 3B4h/3B5h
// [R14] colour graphics index/data 3D4h/3D5h
// [R15] local bus only with graphics disabled
// [R16] wide dram/rom or local bus blocks graphics
// [R17] third rom select routed to chosen pin
// [R18] serial and infrared share uart, one active
// [R19] cpu writes index before data access
// [R20] word write to index splits index,data
// [R21] clock/cmos index 70h, data 71h
// [R22] unclaimed cycles forwarded to expansion bus
// [R23] straps constant until next reset
module iopdc_top #(
  parameter ROM_PINS = 15
) (
  input wire clk_in,
  input wire rst_in,
  input wire strap_width_bit0_in,
  input wire strap_width_bit1_in,
  input wire io_req_in,
  input wire io_wr_in,
  input wire io_word_in,
  input wire [15:0] io_addr_in,
  input wire [15:0] io_wdata_in,
  input wire [7:0] periph_rdata_in,
  input wire local_device_claim_in,
  input wire [7:0] ctlb_status_in,
  output reg [15:0] io_rdata_out,
  output reg io_ack_out,
  output reg [3:0] target_sel_out,
  output reg target_wr_out,
  output reg [15:0] target_addr_out,
  output reg [7:0] target_wdata_out,
  output reg target_stb_out,
  output reg expansion_stb_out,
  output reg [1:0] boot_width_out,
  output wire strap_pulldown_en_out,
  output wire dram_pins_en_out,
  output reg gfx_enable_out,
  output reg local_bus_enable_out,
  output reg dram32_out,
  output reg [ROM_PINS-1:0] third_rom_select_route_out,
  output reg uart_to_irda_out,
  output reg uart_to_serial_out,
  output reg a20_gate_out,
  output reg cpu_reset_out,
  output reg [7:0] ctlb_out,
  output reg [7:0] ctla_out
);

  // ************************************************************
  // strap capture
  // ************************************************************
  reg s0_meta_q;
  reg s1_meta_q;
  reg s0_q;
  reg s1_q;
  reg [1:0] width_q;

  // weak pull-down held on always; pins only feed dram after reset
  assign strap_pulldown_en_out = 1'b1; // see [R03]
  assign dram_pins_en_out = ~rst_in; // see [R02]

  // straps come from pins, so they pass two flops first; the capture
  // lags the pins by two cycles and reset must be held at least three
  always @(posedge clk_in)
  begin
    s0_meta_q <= strap_width_bit0_in;
    s1_meta_q <= strap_width_bit1_in;
    s0_q <= s0_meta_q;
    s1_q <= s1_meta_q;
  end

  // latched each reset cycle, frozen afterwards
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      width_q <= {s1_q, s0_q}; // see [R01]
    end
    boot_width_out <= width_q; // see [R23]
  end

  // ************************************************************
  // address decode
  // ************************************************************
  reg [3:0] sel;
  reg internal_hit;

  // one hit per claimed range; the graphics ports only answer while
  // the graphics controller is enabled, else they go out on the bus
  wire hit_pic = (io_addr_in == `IOPDC_A_PIC0) ||
    (io_addr_in == `IOPDC_A_PIC0 + 16'h0001); // see [R05]
  wire hit_setup = (io_addr_in == `IOPDC_A_SETUP_IDX) ||
    (io_addr_in == `IOPDC_A_SETUP_DAT); // see [R04]
  wire hit_pit = (io_addr_in >= `IOPDC_A_PIT0) &&
    (io_addr_in <= `IOPDC_A_PIT3); // see [R06]
  wire hit_ctlb = (io_addr_in == `IOPDC_A_CTLB); // see [R07]
  wire hit_clock = (io_addr_in == `IOPDC_A_CLK_IDX) ||
    (io_addr_in == `IOPDC_A_CLK_DAT); // see [R21]
  wire hit_scr = (io_addr_in == `IOPDC_A_SCR0) || // see [R09]
    ((io_addr_in >= `IOPDC_A_SCR1) && (io_addr_in <= `IOPDC_A_SCR2)) ||
    (io_addr_in == `IOPDC_A_SCR3) ||
    ((io_addr_in >= `IOPDC_A_SCR4) && (io_addr_in <= `IOPDC_A_SCR5));
  // own byte registers: claimed here but never strobed outward
  wire hit_own = (io_addr_in == `IOPDC_A_CTLA) || // see [R10]
    (io_addr_in == `IOPDC_A_A20) || // see [R11]
    (io_addr_in == `IOPDC_A_CPURST); // see [R12]
  // odd addresses in the dma range stay unclaimed
  wire hit_dma = (io_addr_in >= `IOPDC_A_DMA0) &&
    (io_addr_in <= `IOPDC_A_DMA1) && !io_addr_in[0]; // see [R08]
  wire hit_mono = (io_addr_in == `IOPDC_A_MONO_IDX) ||
    (io_addr_in == `IOPDC_A_MONO_DAT); // see [R13]
  wire hit_col = (io_addr_in == `IOPDC_A_COL_IDX) ||
    (io_addr_in == `IOPDC_A_COL_DAT); // see [R14]
  wire hit_gfx = gfx_enable_out && (hit_mono || hit_col);
  wire hit_card = (io_addr_in == `IOPDC_A_CARD_IDX) ||
    (io_addr_in == `IOPDC_A_CARD_DAT);
  wire hit_local = local_bus_enable_out && local_device_claim_in;

  always @*
  begin
    sel = `IOPDC_S_NONE;
    if (hit_pic)
      sel = `IOPDC_S_PIC;
    else if (hit_setup || hit_own)
      sel = `IOPDC_S_SETUP;
    else if (hit_pit)
      sel = `IOPDC_S_PIT;
    else if (hit_ctlb)
      sel = `IOPDC_S_CTLB;
    else if (hit_clock)
      sel = `IOPDC_S_CLOCK;
    else if (hit_scr)
      sel = `IOPDC_S_SCR;
    else if (hit_dma)
      sel = `IOPDC_S_DMA;
    else if (hit_gfx)
      sel = `IOPDC_S_GFX;
    else if (hit_card)
      sel = `IOPDC_S_CARD;
    else if (hit_local)
      sel = `IOPDC_S_LOCAL; // see [R15]
    // whatever is left goes out on the expansion bus
    internal_hit = (sel != `IOPDC_S_NONE); // see [R22]
  end

  // ************************************************************
  // cycle sequencer: word writes to an index port split in two
  // ************************************************************
  localparam ST_IDLE = 2'd0;
  localparam ST_HI = 2'd1;
  localparam ST_DONE = 2'd2;

  reg [1:0] st_q;
  reg [7:0] setup_index_q;
  reg [7:0] hi_byte_q;
  reg [15:0] addr_q;
  reg [3:0] sel_q;
  wire is_index = (io_addr_in == `IOPDC_A_SETUP_IDX) ||
    (io_addr_in == `IOPDC_A_CLK_IDX) ||
    (io_addr_in == `IOPDC_A_MONO_IDX) ||
    (io_addr_in == `IOPDC_A_COL_IDX) ||
    (io_addr_in == `IOPDC_A_CARD_IDX);
  wire [7:0] wb = io_wdata_in[7:0];

  // ************************************************************
  // feature interlocks and third rom select routing
  // ************************************************************
  // byte written this cycle: the low byte on the first phase, the
  // held high byte on the data phase of a split word write
  wire [7:0] wr_byte = (st_q == ST_HI) ? hi_byte_q : wb;
  wire [ROM_PINS-1:0] route_d;
  reg feat_gfx_d;
  reg feat_lbus_d;
  reg feat_dram32_d;
  reg feat_irda_d;

  // interlocks act on the write itself, so the enables never show a
  // forbidden pair, not even for one cycle; the cost is that a
  // refused bit reads back as zero rather than as written
  always @*
  begin
    // local bus and graphics share control signals
    feat_lbus_d = wr_byte[`IOPDC_F_LBUS] &
      ~wr_byte[`IOPDC_F_GFX]; // see [R15]
    feat_dram32_d = wr_byte[`IOPDC_F_DRAM32];
    // wide dram, wide boot memory or the local bus lock graphics out
    feat_gfx_d = wr_byte[`IOPDC_F_GFX] &
      ~wr_byte[`IOPDC_F_LBUS] &
      ~wr_byte[`IOPDC_F_DRAM32] &
      (boot_width_out != `IOPDC_ROM32); // see [R16]
    feat_irda_d = wr_byte[`IOPDC_F_IRDA]; // see [R18]
  end

  // one decoder per general select pin; a pin number at or above the
  // pin count leaves the third rom select unrouted
  genvar gi;
  generate
    for (gi = 0; gi < ROM_PINS; gi = gi + 1)
    begin : g_route
      assign route_d[gi] = wr_byte[`IOPDC_F_ROM_EN] &&
        ({28'h0000000, wr_byte[3:0]} == gi); // see [R17]
    end
  endgenerate

  // register writes from the first phase of a cycle and from the data phase of a split word write
  task setup_write;
    input [15:0] a;
    input [7:0] d;
    begin
      case (a)
        `IOPDC_A_SETUP_IDX: setup_index_q <= d; // see [R19]
        `IOPDC_A_CTLA: ctla_out <= d; // see [R10]
        `IOPDC_A_A20: a20_gate_out <= d[0]; // see [R11]
        `IOPDC_A_CPURST: cpu_reset_out <= d[0]; // see [R12]
        `IOPDC_A_SETUP_DAT:
        begin
          case (setup_index_q)
            `IOPDC_X_FEAT:
            begin
              local_bus_enable_out <= feat_lbus_d; // see [R15]
              dram32_out <= feat_dram32_d;
              gfx_enable_out <= feat_gfx_d; // see [R16]
              uart_to_irda_out <= feat_irda_d; // see [R18]
              uart_to_serial_out <= ~feat_irda_d; // see [R18]
            end
            `IOPDC_X_ROMSEL:
              third_rom_select_route_out <= route_d; // see [R17]
            default: ;
          endcase
        end
        default: ;
      endcase
    end
  endtask

  // ************************************************************
  // read data
  // ************************************************************
  reg [15:0] rd_word_d;

  // built from the latched address and index, so a cpu that moves its
  // address early cannot change the answer it is about to take
  always @*
  begin
    rd_word_d = 16'h0000;
    case (addr_q)
      `IOPDC_A_SETUP_IDX: rd_word_d[7:0] = setup_index_q; // see [R04]
      `IOPDC_A_CTLA: rd_word_d[7:0] = ctla_out; // see [R10]
      `IOPDC_A_A20: rd_word_d[0] = a20_gate_out; // see [R11]
      `IOPDC_A_CPURST: rd_word_d[0] = cpu_reset_out; // see [R12]
      `IOPDC_A_CTLB:
        rd_word_d[7:0] = ctlb_status_in | ctlb_out; // see [R07]
      `IOPDC_A_SETUP_DAT:
      begin
        case (setup_index_q)
          `IOPDC_X_FEAT:
            rd_word_d[3:0] = {uart_to_irda_out, dram32_out,
              local_bus_enable_out, gfx_enable_out};
          `IOPDC_X_STRAP: rd_word_d[1:0] = boot_width_out; // see [R01]
          // other setup indexes read as zero
          default: rd_word_d[7:0] = 8'h00;
        endcase
      end
      default: rd_word_d[7:0] = periph_rdata_in;
    endcase
  end

  // a request is taken only while idle; a cpu that keeps its request
  // up past the acknowledge starts a second cycle, so it must drop it
  // in the acknowledge cycle

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      st_q <= ST_IDLE;
      setup_index_q <= `IOPDC_RST_BYTE;
      hi_byte_q <= `IOPDC_RST_BYTE;
      addr_q <= 16'h0000;
      sel_q <= `IOPDC_S_NONE;
      io_ack_out <= 1'b0;
      io_rdata_out <= 16'h0000;
      target_sel_out <= `IOPDC_S_NONE;
      target_wr_out <= 1'b0;
      target_addr_out <= 16'h0000;
      target_wdata_out <= `IOPDC_RST_BYTE;
      target_stb_out <= 1'b0;
      expansion_stb_out <= 1'b0;
      gfx_enable_out <= 1'b0;
      local_bus_enable_out <= 1'b0;
      dram32_out <= 1'b0;
      third_rom_select_route_out <= {ROM_PINS{1'b0}};
      uart_to_irda_out <= 1'b0;
      uart_to_serial_out <= 1'b1;
      a20_gate_out <= 1'b0;
      cpu_reset_out <= 1'b0;
      ctlb_out <= `IOPDC_RST_BYTE;
      ctla_out <= `IOPDC_RST_BYTE;
    end
    else
    begin
      io_ack_out <= 1'b0;
      target_stb_out <= 1'b0;
      expansion_stb_out <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          if (io_req_in)
          begin
            addr_q <= io_addr_in;
            sel_q <= sel;
            hi_byte_q <= io_wdata_in[15:8];
            target_sel_out <= sel;
            target_wr_out <= io_wr_in;
            target_addr_out <= io_addr_in;
            target_wdata_out <= wb;
            target_stb_out <= internal_hit &&
              sel != `IOPDC_S_SETUP;
            expansion_stb_out <= !internal_hit; // see [R22]
            if (io_wr_in)
            begin
              setup_write(io_addr_in, wb);
              if (io_addr_in == `IOPDC_A_CTLB)
                ctlb_out <= wb; // see [R07]
            end
            if (io_wr_in && io_word_in && is_index)
              st_q <= ST_HI; // see [R20]
            else
              st_q <= ST_DONE;
          end
        end
        ST_HI:
        begin
          // data byte goes to the port just above the index
          target_addr_out <= addr_q + 16'h0001; // see [R20]
          target_wdata_out <= hi_byte_q;
          // an unclaimed index port forwards its data byte as well
          target_stb_out <= sel_q != `IOPDC_S_SETUP &&
            sel_q != `IOPDC_S_NONE;
          expansion_stb_out <= sel_q == `IOPDC_S_NONE; // see [R22]
          if (sel_q == `IOPDC_S_SETUP)
            setup_write(addr_q + 16'h0001, hi_byte_q);
          st_q <= ST_DONE;
        end
        ST_DONE:
        begin
          io_ack_out <= 1'b1;
          io_rdata_out <= rd_word_d;
          st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

endmodule

/* File: verif/iopdc_checker_asserts.sv */
`include "iopdc_defines.vh"
module iopdc_checker #(
  parameter ROM_PINS = 15
) (
  input wire logic clk_in, rst_in, io_req_in, io_wr_in, io_word_in,
  input wire logic [15:0] io_addr_in, target_addr_out,
  input wire logic io_ack_out, target_stb_out, expansion_stb_out,
  input wire logic [3:0] target_sel_out,
  input wire logic gfx_enable_out, local_bus_enable_out, dram32_out,
  input wire logic uart_to_irda_out, uart_to_serial_out,
  input wire logic [1:0] boot_width_out,
  input wire logic [ROM_PINS-1:0] third_rom_select_route_out
);
  // ********
  // cycle tracking
  // ********
  logic busy_q;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  always @(posedge clk_in)
    busy_q <= (rst_in || io_ack_out) ? 1'b0 : (busy_q || io_req_in);
  sequence s_take;
    io_req_in && !busy_q && !io_ack_out;
  endsequence
  sequence s_idx_word;
    s_take ##0 (io_wr_in && io_word_in && io_addr_in == `IOPDC_A_SETUP_IDX);
  endsequence
  // ********
  // assertions
  // ********
  byte_ack_a: assert property (s_take ##0 !io_word_in |->
    ##1 !io_ack_out ##1 io_ack_out) else $error("byte ack late");
  word_split_a: assert property (s_idx_word |->
    ##1 !io_ack_out [*2] ##1 io_ack_out) else $error("split ack late");
  dma_even_a: assert property (target_stb_out &&
    target_sel_out == `IOPDC_S_DMA |-> !target_addr_out[0] &&
    target_addr_out >= `IOPDC_A_DMA0 && target_addr_out <= `IOPDC_A_DMA1)
    else $error("dma decode wrong");
  pic_range_a: assert property (target_stb_out &&
    target_sel_out == `IOPDC_S_PIC |-> target_addr_out[15:1] == 15'h0010)
    else $error("pic decode wrong");
  claim_excl_a: assert property (
    !(target_stb_out && expansion_stb_out))
    else $error("cycle claimed twice");
  lbus_gfx_a: assert property (
    !(gfx_enable_out && local_bus_enable_out))
    else $error("lbus with gfx");
  gfx_block_a: assert property (dram32_out ||
    local_bus_enable_out ||
    boot_width_out == `IOPDC_ROM32 |-> !gfx_enable_out)
    else $error("gfx not blocked");
  uart_one_a: assert property (
    uart_to_irda_out != uart_to_serial_out)
    else $error("uart routing");
  rom_route_a: assert property (
    $onehot0(third_rom_select_route_out))
    else $error("route not one-hot");
  strap_hold_a: assert property ($past(!rst_in) &&
    $past(!rst_in, 2) |-> $stable(boot_width_out))
    else $error("straps changed");
endmodule

/* File: verif/iopdc_periph_model.sv */
module iopdc_periph_model (
  input wire logic clk_in,
  input wire logic [3:0] target_sel_out,
  input wire logic [15:0] target_addr_out,
  output logic [7:0] periph_rdata_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_q = 8'h00;
  always @(posedge clk_in)
    last_q <= periph_rdata_in;
  // unselected bus toggles so stale data can never look right
  assign periph_rdata_in = (target_sel_out == 4'h0) ? ~last_q :
    target_addr_out[7:0] ^ 8'h5A;
endmodule

/* File: verif/io_port_decode_and_config_tb.sv */
`include "iopdc_defines.vh"
module io_port_decode_and_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, rst_in = 1'b1, io_req_in = 1'b0, io_wr_in = 1'b0;
  logic io_word_in = 1'b0, local_device_claim_in = 1'b0, exp_q;
  logic strap_width_bit0_in = 1'b0, strap_width_bit1_in = 1'b1;
  logic [15:0] io_addr_in = 16'h0000, io_wdata_in = 16'h0000, q;
  logic [7:0] ctlb_status_in = 8'h41, periph_rdata_in, ctlb_out, ctla_out;
  logic [15:0] io_rdata_out, target_addr_out;
  logic [7:0] target_wdata_out;
  logic [3:0] target_sel_out, sel_q;
  logic [1:0] boot_width_out;
  logic [14:0] third_rom_select_route_out;
  logic io_ack_out, target_wr_out, target_stb_out, expansion_stb_out;
  logic strap_pulldown_en_out, dram_pins_en_out, gfx_enable_out;
  logic local_bus_enable_out, dram32_out, uart_to_irda_out;
  logic uart_to_serial_out, a20_gate_out, cpu_reset_out;
  logic sw_q;
  logic [15:0] sa_q;
  logic [7:0] sd_q;
  int n_errors = 0, checks = 0;
  logic [15:0] ta [15] = '{16'h20, 16'h21, 16'h40, 16'h43, 16'h61,
    16'h71, 16'h80, 16'h86, 16'h8F, 16'h81, 16'hDE, 16'hDF, 16'h3E1,
    16'h3B5, 16'h300};
  logic [3:0] ts [15] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'h5, 4'h5,
    4'h5, 4'hF, 4'h6, 4'hF, 4'h8, 4'hF, 4'hF};
  logic [7:0] fv [6] = '{8'h01, 8'h03, 8'h02, 8'h04, 8'h05, 8'h08};
  logic [4:0] fe [6] = '{5'h11, 5'h10, 5'h12, 5'h14, 5'h14, 5'h08};
  iopdc_top DUT (.*);
  iopdc_periph_model u_periph (.*);
  initial
  begin
    forever #10 clk_in = ~clk_in;
  end
  // ********
  // bus tasks
  // ********
  always @(posedge clk_in)
  begin
    if (target_stb_out === 1'b1) sel_q <= target_sel_out;
    if (expansion_stb_out === 1'b1) exp_q <= 1'b1;
    if (target_stb_out === 1'b1)
      {sw_q, sa_q, sd_q} <= {target_wr_out, target_addr_out,
        target_wdata_out};
  end
  task automatic chk(input [15:0] e, g, input string s);
    checks++;
    if (e !== g)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic io(input logic w, b, input logic [15:0] a, d);
    int n;
    @(negedge clk_in);
    {io_req_in, io_wr_in, io_word_in} = {1'b1, w, b};
    {io_addr_in, io_wdata_in} = {a, d};
    sel_q = 4'hF;
    exp_q = 1'b0;
    n = 0;
    do
    begin
      @(negedge clk_in);
      n++;
    end while (io_ack_out !== 1'b1 && n < 8);
    q = io_rdata_out;
    io_req_in = 1'b0;
    chk(1, io_ack_out, "ack");
  endtask
  task automatic print_verdict;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #200us;
    n_errors++;
    print_verdict;
  end
  // ********
  // tests
  // ********
  initial
  begin
    repeat (10) @(negedge clk_in);
    rst_in = 1'b0;
    @(negedge clk_in);
    chk(`IOPDC_ROM32, boot_width_out, "boot width");
    chk(1, dram_pins_en_out, "dram pins");
    chk(1, strap_pulldown_en_out, "pulldown");
    {strap_width_bit1_in, strap_width_bit0_in} = 2'b01;
    io(1, 0, 16'h0022, 16'h00F0);
    io(1, 0, 16'h0023, 16'h0001);
    chk(0, gfx_enable_out, "gfx wide rom");
    chk(`IOPDC_ROM32, boot_width_out, "strap hold");
    {strap_width_bit1_in, strap_width_bit0_in} = 2'b00;
    rst_in = 1'b1;
    repeat (10) @(negedge clk_in);
    chk(0, dram_pins_en_out, "pins in reset");
    rst_in = 1'b0;
    @(negedge clk_in);
    chk(0, boot_width_out, "boot low");
    chk(1, uart_to_serial_out, "serial");
    io(1, 0, 16'h0061, 16'h003C);
    chk(8'h3C, ctlb_out, "ctlb");
    for (int i = 0; i < 15; i++)
    begin
      io(0, 0, ta[i], 16'h0000);
      chk(ts[i], sel_q, "select");
      chk(ts[i] == 4'hF, exp_q, "forward");
      if (ts[i] != 4'hF)
        chk(ts[i] == 4'h3 ? 8'h7D : ta[i][7:0] ^ 8'h5A,
          q[7:0], "rd");
    end
    for (int i = 0; i < 6; i++)
    begin
      io(1, 1, 16'h0022, {fv[i], 8'hF0});
      chk(fe[i], {uart_to_serial_out, uart_to_irda_out, dram32_out,
        local_bus_enable_out, gfx_enable_out}, "features");
    end
    io(0, 0, 16'h0023, 16'h0000);
    chk(8'h08, q[7:0], "setup data");
    io(1, 1, 16'h0070, 16'h5A0C);
    chk(16'h0071, sa_q, "split addr");
    chk(8'h5A, sd_q, "split data");
    chk(1, sw_q, "split write");
    io(1, 1, 16'h0022, 16'h01F0);
    io(0, 0, 16'h03B5, 16'h0000);
    chk(`IOPDC_S_GFX, sel_q, "mono gfx");
    io(0, 0, 16'h03D4, 16'h0000);
    chk(`IOPDC_S_GFX, sel_q, "colour gfx");
    io(1, 1, 16'h0022, 16'h02F0);
    io(1, 1, 16'h03B4, 16'h1122);
    chk(1, exp_q, "gfx off fwd");
    chk(4'hF, sel_q, "gfx off sel");
    local_device_claim_in = 1'b1;
    io(0, 0, 16'h0300, 16'h0000);
    chk(0, exp_q, "local claim");
    local_device_claim_in = 1'b0;
    io(1, 1, 16'h0022, 16'h17F1);
    chk(15'h0080, third_rom_select_route_out, "rom route");
    io(0, 0, 16'h0022, 16'h0000);
    chk(8'hF1, q[7:0], "setup index");
    io(1, 0, 16'h0092, 16'h00A5);
    io(0, 0, 16'h0092, 16'h0000);
    chk(8'hA5, q[7:0], "ctla read");
    chk(8'hA5, ctla_out, "ctla");
    io(1, 0, 16'h00EE, 16'h0001);
    chk(1, a20_gate_out, "a20");
    io(1, 0, 16'h00EF, 16'h0001);
    chk(1, cpu_reset_out, "cpu reset");
    print_verdict;
  end
endmodule
bind iopdc_top iopdc_checker #(.ROM_PINS(ROM_PINS)) u_chk (.*);
